//--- hdl/seep_params.svh
// Purpose: Shared constants of the serial EEPROM command port
// Assumes: Included by design files by bare name
// Notes:   Counts derived from the 100 MHz system clock
`ifndef SEEP_PARAMS_SVH
`define SEEP_PARAMS_SVH

`define SEEP_OP_READ      2'h2
`define SEEP_OP_ERASE     2'h3
`define SEEP_OP_WRITE     2'h1
`define SEEP_OP_EXT       2'h0
`define SEEP_SUB_ENABLE   2'h3
`define SEEP_SUB_DISABLE  2'h0
`define SEEP_SUB_ERASEALL 2'h2
`define SEEP_SUB_WRITEALL 2'h1

`define SEEP_HDR16        5'h08
`define SEEP_HDR8         5'h09
`define SEEP_WBITS16      5'h10
`define SEEP_WBITS8       5'h08
`define SEEP_ONE5         5'h01
`define SEEP_ADDR_ONE     7'h01
`define SEEP_MEM_BYTES    128
`define SEEP_ERASED       8'hFF
`define SEEP_ORG_SETTLE   2'h3

`define SEEP_WRITE_CYCLE_MS 5
`define SEEP_CLK_KHZ        100000
`define SEEP_WRITE_CYCLES   (`SEEP_WRITE_CYCLE_MS * `SEEP_CLK_KHZ)
`define SEEP_TMR_W          20

`endif

//--- hdl/seep_pkg.sv
// Purpose: Types of the serial EEPROM command port
// Assumes: Nothing beyond the language
// Notes:   Enums carry no explicit codes
package seep_pkg;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ,
        CMD_ERASE,
        CMD_WRITE,
        PROGRAM_ENABLE_CMD,
        PROGRAM_DISABLE_CMD,
        ERASE_ALL_CMD,
        WRITE_ALL_CMD
    } seep_cmd_e;

    typedef enum logic [2:0] {
        LINK_WAIT_START,
        LINK_HEADER,
        LINK_DATA,
        LINK_READ,
        LINK_IGNORE
    } seep_link_e;

endpackage

//--- hdl/seep_timer_if.sv
// Purpose: Start and busy handshake between command port and cycle timer
// Assumes: Both ends on clk_sys
// Notes:   done is a one-cycle pulse in the last busy cycle
`timescale 1ns/1ps
interface seep_timer_if;
    logic start;
    logic busy;
    logic done;
    modport core  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

//--- hdl/seep_timer.sv
// Purpose: Self-timed erase and program cycle timer
// Assumes: start only honoured while idle
// Notes:   CYCLES may be shortened for simulation
`timescale 1ns/1ps
`include "seep_params.svh"
module seep_timer
    import seep_pkg::*;
#(
    parameter int unsigned CYCLES = `SEEP_WRITE_CYCLES
) (
    input  wire logic     clk_sys,
    input  wire logic     rst,
    seep_timer_if.timer   tmr
);

    logic [`SEEP_TMR_W-1:0] cnt_q;
    logic                   busy_q;

    // Count down the cycle on the system clock alone
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (tmr.start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q  <= `SEEP_TMR_W'(CYCLES - 1);
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Done marks the final busy cycle so memory commits as busy falls
    assign tmr.busy = busy_q;
    assign tmr.done = busy_q && (cnt_q == '0);

endmodule // seep_timer

//--- hdl/seep_command_port.sv
// Purpose: Serial EEPROM command decoder, read streamer and program control
// Assumes: Host waits for ready before a new instruction after programming
// Notes:   Link logic runs on serial_clock_in; array and timer on clk_sys
`timescale 1ns/1ps
`include "seep_params.svh"
module seep_command_port
    import seep_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SEEP_WRITE_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic serial_clock_in,
    input  wire logic serial_select,
    input  wire logic serial_data_in,
    output wire logic serial_data_out,
    output wire logic serial_data_oe,
    input  wire logic organisation_strap
);

    // ---------------- System-domain declarations
    logic [7:0]  memQ [`SEEP_MEM_BYTES];
    logic        strapM_q;
    logic        strapS_q;
    logic [1:0]  orgCnt_q;
    logic        x16_q;
    logic        csM_q;
    logic        csS_q;
    logic        csP_q;
    logic        tglM_q;
    logic        tglS_q;
    logic        tglP_q;
    logic        pend_q;
    logic        enable_q;
    logic        show_q;
    logic        statusOe_q;
    logic        statusOut_q;
    seep_cmd_e   opKind_q;
    logic [6:0]  opAddr_q;
    logic [15:0] opData_q;
    logic        csFall;
    logic        tglEdge;
    logic        go;
    logic        progKind;

    // ---------------- Link-domain declarations
    logic        linkRst;
    logic        orgM_q;
    logic        x16l_q;
    seep_link_e  linkSt_q;
    logic [4:0]  bitCnt_q;
    logic [8:0]  hdrSh_q;
    logic [15:0] rdSh_q;
    logic [6:0]  rdAddr_q;
    logic        rdOut_q;
    logic        rdOe_q;
    seep_cmd_e   capKind_q;
    logic [6:0]  capAddr_q;
    logic [15:0] capData_q;
    logic        capTgl_q;
    logic [8:0]  hdrNext;
    logic [4:0]  hdrLast;
    logic [4:0]  wordLast;
    logic        hdrDone;
    logic        dataDone;
    seep_cmd_e   hdrKind;
    logic [6:0]  hdrAddr;
    logic [6:0]  rdNextA;

    seep_timer_if tmr ();

    // Opcode and extended sub-code decode of a complete header
    function automatic seep_cmd_e decodeCmd(input logic [8:0] sh, input logic x16);
        logic [1:0] op;
        logic [1:0] sub;
        op  = x16 ? sh[7:6] : sh[8:7];
        sub = x16 ? sh[5:4] : sh[6:5];
        case (op)
            `SEEP_OP_READ:  decodeCmd = CMD_READ;
            `SEEP_OP_ERASE: decodeCmd = CMD_ERASE;
            `SEEP_OP_WRITE: decodeCmd = CMD_WRITE;
            default: begin
                case (sub)
                    `SEEP_SUB_ENABLE:   decodeCmd = PROGRAM_ENABLE_CMD;
                    `SEEP_SUB_DISABLE:  decodeCmd = PROGRAM_DISABLE_CMD;
                    `SEEP_SUB_ERASEALL: decodeCmd = ERASE_ALL_CMD;
                    default:            decodeCmd = WRITE_ALL_CMD;
                endcase
            end
        endcase
    endfunction

    // Word fetch; a byte read sits left-aligned so the MSB is always bit 15
    function automatic logic [15:0] fetchWord(input logic [6:0] a, input logic x16);
        if (x16) begin
            fetchWord = {memQ[{a[5:0], 1'b1}], memQ[{a[5:0], 1'b0}]};
        end else begin
            fetchWord = {memQ[a], 8'h00};
        end
    endfunction

    // ================= System clock domain

    // Strap caught after reset release; the pad pull-up makes floating read high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strapM_q <= 1'b1;
            strapS_q <= 1'b1;
            orgCnt_q <= 2'h0;
            x16_q    <= 1'b1;
        end else begin
            strapM_q <= organisation_strap;
            strapS_q <= strapM_q;
            if (orgCnt_q != `SEEP_ORG_SETTLE) begin
                orgCnt_q <= orgCnt_q + 2'h1;
                x16_q    <= strapS_q;
            end
        end
    end

    // Select and command toggle cross into clk_sys through two flops each
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csM_q  <= 1'b0;
            csS_q  <= 1'b0;
            csP_q  <= 1'b0;
            tglM_q <= 1'b0;
            tglS_q <= 1'b0;
            tglP_q <= 1'b0;
        end else begin
            csM_q  <= serial_select;
            csS_q  <= csM_q;
            csP_q  <= csS_q;
            tglM_q <= capTgl_q;
            tglS_q <= tglM_q;
            tglP_q <= tglS_q;
        end
    end

    assign csFall   = csP_q && !csS_q;
    assign tglEdge  = tglS_q ^ tglP_q;
    assign go       = csFall && (pend_q || tglEdge);
    assign progKind = (capKind_q == CMD_ERASE) || (capKind_q == CMD_WRITE) ||
                      (capKind_q == ERASE_ALL_CMD) || (capKind_q == WRITE_ALL_CMD);

    // A finished instruction waits for select to fall; a fall consumes it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (go) begin
            pend_q <= 1'b0;
        end else if (tglEdge) begin
            pend_q <= 1'b1;
        end
    end

    // Programming enable; reset stands for both power-up and power-down
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else if (go && (capKind_q == PROGRAM_ENABLE_CMD)) begin
            enable_q <= 1'b1;
        end else if (go && (capKind_q == PROGRAM_DISABLE_CMD)) begin
            enable_q <= 1'b0;
        end
    end

    // Start only when enabled; disabled requests drop without trace
    assign tmr.start = go && progKind && enable_q && !tmr.busy;

    // Latch the operation so a later instruction cannot disturb it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opKind_q <= CMD_NONE;
            opAddr_q <= 7'h00;
            opData_q <= 16'h0000;
        end else if (tmr.start) begin
            opKind_q <= capKind_q;
            opAddr_q <= capAddr_q;
            opData_q <= capData_q;
        end
    end

    // Commit at the end of the cycle; write folds erase and program in one
    always_ff @(posedge clk_sys) begin
        if (tmr.done) begin
            case (opKind_q)
                CMD_ERASE: begin
                    if (x16_q) begin
                        memQ[{opAddr_q[5:0], 1'b1}] <= `SEEP_ERASED;
                        memQ[{opAddr_q[5:0], 1'b0}] <= `SEEP_ERASED;
                    end else begin
                        memQ[opAddr_q] <= `SEEP_ERASED;
                    end
                end
                CMD_WRITE: begin
                    if (x16_q) begin
                        memQ[{opAddr_q[5:0], 1'b1}] <= opData_q[15:8];
                        memQ[{opAddr_q[5:0], 1'b0}] <= opData_q[7:0];
                    end else begin
                        memQ[opAddr_q] <= opData_q[7:0];
                    end
                end
                ERASE_ALL_CMD: begin
                    for (int i = 0; i < `SEEP_MEM_BYTES; i++) begin
                        memQ[i] <= `SEEP_ERASED;
                    end
                end
                WRITE_ALL_CMD: begin
                    for (int i = 0; i < `SEEP_MEM_BYTES; i++) begin
                        memQ[i] <= (x16_q && i[0]) ? opData_q[15:8] : opData_q[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Status stays armed until select falls with the cycle finished
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            show_q <= 1'b0;
        end else if (tmr.start) begin
            show_q <= 1'b1;
        end else if (csFall && !tmr.busy) begin
            show_q <= 1'b0;
        end
    end

    // Busy shows low, ready high, only while select is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            statusOe_q  <= 1'b0;
            statusOut_q <= 1'b1;
        end else begin
            statusOe_q  <= csS_q && show_q;
            statusOut_q <= !tmr.busy;
        end
    end

    seep_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tmr     (tmr)
    );

    // ================= Link clock domain

    // Deselect clears the frame state at once, so no edge after a frame is needed
    assign linkRst = rst || !serial_select;

    // Organisation is static after reset; two link flops still guard it
    always_ff @(posedge serial_clock_in or posedge rst) begin
        if (rst) begin
            orgM_q <= 1'b1;
            x16l_q <= 1'b1;
        end else begin
            orgM_q <= x16_q;
            x16l_q <= orgM_q;
        end
    end

    assign hdrNext  = {hdrSh_q[7:0], serial_data_in};
    assign hdrLast  = 5'((x16l_q ? `SEEP_HDR16 : `SEEP_HDR8) - `SEEP_ONE5);
    assign wordLast = 5'((x16l_q ? `SEEP_WBITS16 : `SEEP_WBITS8) - `SEEP_ONE5);
    assign hdrDone  = (linkSt_q == LINK_HEADER) && (bitCnt_q == hdrLast);
    assign dataDone = (linkSt_q == LINK_DATA) && (bitCnt_q == wordLast);
    assign hdrKind  = decodeCmd(hdrNext, x16l_q);
    assign hdrAddr  = x16l_q ? {1'b0, hdrNext[5:0]} : hdrNext[6:0];
    assign rdNextA  = x16l_q ? {1'b0, 6'(rdAddr_q[5:0] + 6'h01)}
                             : 7'(rdAddr_q + `SEEP_ADDR_ONE);

    // Frame sequencer; array read crosses unsynchronised because it is
    // written only while busy, and the host does not read until ready
    always_ff @(posedge serial_clock_in or posedge linkRst) begin
        if (linkRst) begin
            linkSt_q <= LINK_WAIT_START;
            bitCnt_q <= 5'h00;
            hdrSh_q  <= 9'h000;
            rdSh_q   <= 16'h0000;
            rdAddr_q <= 7'h00;
            rdOut_q  <= 1'b0;
            rdOe_q   <= 1'b0;
        end else begin
            case (linkSt_q)
                LINK_WAIT_START: begin
                    if (serial_data_in) begin
                        linkSt_q <= LINK_HEADER;
                        bitCnt_q <= 5'h00;
                        hdrSh_q  <= 9'h000;
                    end
                end
                LINK_HEADER: begin
                    hdrSh_q  <= hdrNext;
                    bitCnt_q <= bitCnt_q + `SEEP_ONE5;
                    if (hdrDone) begin
                        bitCnt_q <= 5'h00;
                        if (hdrKind == CMD_READ) begin
                            linkSt_q <= LINK_READ;
                            rdAddr_q <= hdrAddr;
                            rdSh_q   <= fetchWord(hdrAddr, x16l_q);
                            rdOut_q  <= 1'b0;
                            rdOe_q   <= 1'b1;
                        end else if ((hdrKind == CMD_WRITE) || (hdrKind == WRITE_ALL_CMD)) begin
                            linkSt_q <= LINK_DATA;
                        end else begin
                            linkSt_q <= LINK_IGNORE;
                        end
                    end
                end
                LINK_DATA: begin
                    bitCnt_q <= bitCnt_q + `SEEP_ONE5;
                    if (dataDone) begin
                        linkSt_q <= LINK_IGNORE;
                    end
                end
                LINK_READ: begin
                    rdOut_q <= rdSh_q[15];
                    if (bitCnt_q == wordLast) begin
                        bitCnt_q <= 5'h00;
                        rdAddr_q <= rdNextA;
                        rdSh_q   <= fetchWord(rdNextA, x16l_q);
                    end else begin
                        bitCnt_q <= bitCnt_q + `SEEP_ONE5;
                        rdSh_q   <= {rdSh_q[14:0], 1'b0};
                    end
                end
                LINK_IGNORE: begin
                    // Extra clocks after a complete instruction are ignored
                end
                default: begin
                    linkSt_q <= LINK_WAIT_START;
                end
            endcase
        end
    end

    // Captured command survives deselect; the toggle hands it to clk_sys
    always_ff @(posedge serial_clock_in or posedge rst) begin
        if (rst) begin
            capKind_q <= CMD_NONE;
            capAddr_q <= 7'h00;
            capData_q <= 16'h0000;
            capTgl_q  <= 1'b0;
        end else begin
            if (hdrDone) begin
                capKind_q <= hdrKind;
                capAddr_q <= hdrAddr;
            end
            if (linkSt_q == LINK_DATA) begin
                capData_q <= {capData_q[14:0], serial_data_in};
            end
            if (dataDone || (hdrDone && (hdrKind != CMD_READ) &&
                    (hdrKind != CMD_WRITE) && (hdrKind != WRITE_ALL_CMD))) begin
                capTgl_q <= ~capTgl_q;
            end
        end
    end

    // Read data wins over status; raw select forces high impedance at once
    assign serial_data_out = rdOe_q ? rdOut_q : statusOut_q;
    assign serial_data_oe  = serial_select && (rdOe_q || statusOe_q);

endmodule // seep_command_port

//--- sim/seep_host_model.sv
// Purpose: Host side of the three-wire serial link
// Assumes: Link clock period of 15 ns, standing low between frames
// Notes:   A released output line reads as the inverse of the last bit seen
`timescale 1ns/1ps
module seep_host_model
    import seep_pkg::*;
(
    output wire logic serial_clock_in,
    output wire logic serial_select,
    output wire logic serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_oe
);
    logic lastBit;
    logic clkDrv;
    logic selDrv;
    logic dinDrv;

    // Pins follow the task-driven levels so each net has one continuous driver
    assign serial_clock_in = clkDrv;
    assign serial_select   = selDrv;
    assign serial_data_in  = dinDrv;

    // Idle levels at time zero
    initial begin
        clkDrv  = 1'b0;
        selDrv  = 1'b0;
        dinDrv  = 1'b0;
        lastBit = 1'b0;
    end

    // Select moves only while the link clock stands low
    task automatic sel(input logic b);
        #10 selDrv = b;
        dinDrv = ~dinDrv;
        #20;
    endtask

    // MSB first; data moves after the fall, the line is read mid-high
    task automatic shift(input logic [31:0] v, input int n, output logic [31:0] r);
        r = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            dinDrv = v[i];
            #7.5 clkDrv = 1'b1;
            #3.75 r[i] = serial_data_oe ? serial_data_out : ~lastBit;
            lastBit = r[i];
            #3.75 clkDrv = 1'b0;
        end
    endtask
endmodule // seep_host_model

//--- sim/seep_checker.sv
// Purpose: Port-level checks of the serial EEPROM command port
// Assumes: Host drops select after each frame and waits for ready
// Notes:   A frame tracker on the link clock mirrors the header count
`timescale 1ns/1ps
module seep_checker
    import seep_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic serial_clock_in,
    input wire logic serial_select,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic organisation_strap
);
    logic       startedQ;
    logic [4:0] cntQ;
    logic [1:0] opQ;
    logic [4:0] lastHdr;

    // Count of the last address bit after the start bit
    assign lastHdr = organisation_strap ? 5'h07 : 5'h08;

    // Tracker saturates so that long reads never wrap its count
    always_ff @(posedge serial_clock_in or negedge serial_select) begin
        if (!serial_select) begin
            startedQ <= 1'b0;
            cntQ     <= 5'h00;
            opQ      <= 2'h0;
        end else if (!startedQ) begin
            startedQ <= serial_data_in;
        end else begin
            if (cntQ != 5'h1F) cntQ <= cntQ + 5'h01;
            if (cntQ == 5'h00) opQ[1] <= serial_data_in;
            if (cntQ == 5'h01) opQ[0] <= serial_data_in;
        end
    end

    a_ready_holds: assert property (@(posedge clk_sys) disable iff (rst)
        serial_data_oe && serial_data_out && !startedQ |=> !serial_data_oe || serial_data_out)
        else $error("ready status fell back to busy");
    a_reset_quiet: assert property (@(posedge clk_sys) rst |-> !serial_data_oe)
        else $error("output enabled in reset");
    a_lead_quiet: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select) !startedQ |=> !serial_data_oe)
        else $error("output before start bit");
    a_header_quiet: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select) startedQ && cntQ < lastHdr |=> !serial_data_oe)
        else $error("output inside header");
    a_hdr_end: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select)
        startedQ && cntQ == lastHdr |=> serial_data_oe == (opQ == 2'h2))
        else $error("output enable wrong at header end");
    a_dummy_zero: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select)
        startedQ && cntQ == lastHdr && opQ == 2'h2 |=> !serial_data_out)
        else $error("dummy bit not zero");
    a_stream_on: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select)
        startedQ && cntQ > lastHdr && opQ == 2'h2 |-> serial_data_oe)
        else $error("read stream stopped");
    a_nonread_quiet: assert property (@(posedge serial_clock_in)
        disable iff (rst || !serial_select)
        startedQ && cntQ > 5'h01 && opQ != 2'h2 |-> !serial_data_oe)
        else $error("output on a non-read frame");
endmodule // seep_checker

bind seep_command_port seep_checker #(.WRITE_CYCLES(WRITE_CYCLES)) seep_checker_i (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .serial_clock_in    (serial_clock_in),
    .serial_select      (serial_select),
    .serial_data_in     (serial_data_in),
    .serial_data_out    (serial_data_out),
    .serial_data_oe     (serial_data_oe),
    .organisation_strap (organisation_strap)
);

//--- sim/seep_command_port_tb.sv
// Purpose: Self-checking bench of the serial EEPROM command port
// Assumes: Shortened program cycle; strap fixed across each reset
// Notes:   Array has no reset, so every read follows a known program step
`timescale 1ns/1ps
module seep_command_port_tb
    import seep_pkg::*;
;
    localparam int unsigned WCYC = 50;
    logic      clk_sys;
    logic      rst;
    logic      strapLow;
    logic      x8;
    wire logic sclk;
    wire logic ssel;
    wire logic sdin;
    wire logic sdout;
    wire logic soe;
    tri1       strapNet;
    int        compares;
    int        miscompares;

    // Released strap floats up to the wide organisation
    assign strapNet = strapLow ? 1'b0 : 1'bz;

    seep_command_port #(.WRITE_CYCLES(WCYC)) seep_command_port_i (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .serial_clock_in    (sclk),
        .serial_select      (ssel),
        .serial_data_in     (sdin),
        .serial_data_out    (sdout),
        .serial_data_oe     (soe),
        .organisation_strap (strapNet)
    );

    seep_host_model host_i (
        .serial_clock_in (sclk),
        .serial_select   (ssel),
        .serial_data_in  (sdin),
        .serial_data_out (sdout),
        .serial_data_oe  (soe)
    );

    // System clock, 10 ns
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Reset also stands in for a power cycle
    task automatic do_reset();
        #1 rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    // Two idle zeros lead each header
    function automatic logic [31:0] hdr(input logic [1:0] op, input logic [6:0] a);
        return x8 ? {22'h0, 1'b1, op, a} : {23'h0, 1'b1, op, a[5:0]};
    endfunction

    // Sub-code in the top two address bits
    function automatic logic [6:0] sub(input logic [1:0] s);
        return x8 ? {s, 5'h00} : {1'b0, s, 4'h0};
    endfunction

    task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                       input logic wd);
        logic [31:0] r;
        host_i.sel(1'b1);
        host_i.shift(hdr(op, a), x8 ? 12 : 11, r);
        if (wd) host_i.shift({16'h0, d}, x8 ? 8 : 16, r);
        host_i.sel(1'b0);
    endtask

    // Select without clocks shows status; host waits for ready
    task automatic status(input logic busy);
        int n;
        n = 0;
        host_i.sel(1'b1);
        repeat (10) @(posedge clk_sys);
        #1;
        cmp1(soe, busy);
        if (busy) begin
            cmp1(sdout, 1'b0);
            while (sdout !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            if (n >= 200) begin
                miscompares++;
                end_sim();
            end
            cmp1(soe, 1'b1);
        end
        host_i.sel(1'b0);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        cmd(2'h1, a, d, 1'b1);
        status(1'b1);
    endtask

    task automatic refused(input logic [1:0] op, input logic [6:0] a, input logic wd);
        cmd(op, a, 16'h1234, wd);
        status(1'b0);
    endtask

    // Dummy bit, then two words with no new address
    task automatic rd(input logic [6:0] a, input logic [15:0] e0, input logic [15:0] e1);
        logic [31:0] r;
        host_i.sel(1'b1);
        host_i.shift(hdr(2'h2, a), x8 ? 12 : 11, r);
        cmp1(r[0], 1'b0);
        host_i.shift(32'h0, x8 ? 8 : 16, r);
        cmp16(r[15:0], e0);
        host_i.shift(32'h0, x8 ? 8 : 16, r);
        cmp16(r[15:0], e1);
        host_i.sel(1'b0);
    endtask

    task automatic t_erase_all();
        refused(2'h0, sub(2'h2), 1'b0);
        cmd(2'h0, sub(2'h3), 16'h0, 1'b0);
        cmd(2'h0, sub(2'h2), 16'h0, 1'b0);
        status(1'b1);
        rd(7'h00, 16'hFFFF, 16'hFFFF);
        $display("t_erase_all done");
    endtask

    task automatic t_protect();
        cmd(2'h0, sub(2'h0), 16'h0, 1'b0);
        refused(2'h1, 7'h05, 1'b1);
        refused(2'h3, 7'h05, 1'b0);
        refused(2'h0, sub(2'h1), 1'b1);
        refused(2'h0, sub(2'h2), 1'b0);
        rd(7'h05, 16'hFFFF, 16'hFFFF);
        $display("t_protect done");
    endtask

    // Second write over cleared bits shows the erase before program
    task automatic t_write();
        cmd(2'h0, sub(2'h3), 16'h0, 1'b0);
        wr(7'h05, 16'hA5C3);
        wr(7'h06, 16'h0F1E);
        rd(7'h05, 16'hA5C3, 16'h0F1E);
        wr(7'h05, 16'h5A3C);
        rd(7'h04, 16'hFFFF, 16'h5A3C);
        $display("t_write done");
    endtask

    task automatic t_write_all();
        cmd(2'h0, sub(2'h1), 16'h5AC3, 1'b1);
        status(1'b1);
        cmd(2'h3, 7'h00, 16'h0, 1'b0);
        status(1'b1);
        rd(7'h3F, 16'h5AC3, 16'hFFFF);
        $display("t_write_all done");
    endtask

    // Byte organisation after a fresh power cycle
    task automatic t_narrow();
        strapLow = 1'b1;
        x8 = 1'b1;
        do_reset();
        refused(2'h1, 7'h04, 1'b1);
        rd(7'h04, 16'h00C3, 16'h005A);
        cmd(2'h0, sub(2'h3), 16'h0, 1'b0);
        wr(7'h7F, 16'h003C);
        rd(7'h7F, 16'h003C, 16'h00FF);
        $display("t_narrow done");
    endtask

    initial begin
        rst = 1'b1;
        strapLow = 1'b0;
        x8 = 1'b0;
        compares = 0;
        miscompares = 0;
        do_reset();
        t_erase_all();
        t_protect();
        t_write();
        t_write_all();
        t_narrow();
        end_sim();
    end

    // Guard against a hang anywhere
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
endmodule // seep_command_port_tb
